// file: rtl/mbsd_conv.v
// b-slice skip/direct conversion, pair skip permission and vector expansion
// assumes an ahb-lite master on hclk, one transfer at a time
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "mbsd_regs.vh"
// --------------------------------------------------------------
// Contract
// --------------------------------------------------------------
// Contract
// RULE1: permitted b skip input codes skip flag set, pattern zero
// RULE2: refused b skip input becomes direct 16x16 type zero, pattern zero
// RULE3: direct input, conversions on, zero pattern, permitted: skip
// RULE4: same but not permitted: direct 16x16, skip flag clear
// RULE5: skip conversion off keeps zero-pattern direct as direct
// RULE6: nonzero pattern direct stays direct with skip flag clear
// RULE7: direct conversion off keeps type 16h partitioned coding
// RULE8: outside adaptive frame/field the pair permission is one
// RULE9: first macroblock of a pair is always permitted
// RULE10: second is refused if field flag mismatches and first skipped
// RULE11: forced skip refused reverts to l0 16x16 or direct
// RULE12: per-macroblock skip conversion off is honoured
// RULE13: input is vector block plus inline information
// RULE14: unpacked block is 32 or 128 bytes
// RULE15: absent list fields carry zero
// RULE16: large partitions use size 8, 16x16 replicated
// RULE17: 8x16 and 16x8 copied into their quadrants
// RULE18: all-8x8 sub-blocks use size 8 without replication
// RULE19: any minor shape gives size 32 with slot filling
// RULE20: each sub-partition has one fixed slot, others copies
// RULE21: absent list stays zero in all copies
// RULE22: packed count equals vectors sent, summed for type 22
// RULE23: packed count zero, one, two, scaled by sub-shape
// RULE24: vector word holds y in 31:16 and x in 15:0
module mbsd_conv #(
  parameter MV_WORDS = `MBSD_MV_WORDS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg skip_hint_flag,
  output reg [4:0] partition_type_code,
  output reg coded_block_pattern_zero,
  output reg [5:0] vector_block_size,
  output reg [5:0] packed_vector_count,
  output reg result_valid
);
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  reg [7:0] a_addr_r;
  reg a_wr_r;
  reg [3:0] ctrl_r;
  reg [20:0] mbinfo_r;
  reg [23:0] pattern_r;
  reg [4:0] vsel_r;
  reg first_skip_r;
  reg [31:0] mv_r [0:MV_WORDS-1];
  reg [31:0] rdata_nxt;
  wire start;
  wire [4:0] src;
  wire [31:0] vword;
  integer i;
  assign start = a_wr_r && a_addr_r == `MBSD_OFF_CMD && hwdata[0];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr_r <= 8'h00;
      a_wr_r <= 1'b0;
    end else if (hready) begin
      a_addr_r <= {haddr[7:2], 2'h0};
      a_wr_r <= hsel && htrans[1] && hwrite;
    end else begin
      a_wr_r <= a_wr_r;
    end
  end
  // vector words live in the array, loaded word by word (RULE13)
  always @(posedge hclk) begin
    for (i = 0; i < MV_WORDS; i = i + 1)
      if (a_wr_r && a_addr_r == `MBSD_OFF_MVIN + (i[7:0] << 2))
        mv_r[i] <= hwdata; // RULE24
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 4'h0;
      mbinfo_r <= 21'h000000;
      pattern_r <= 24'h000000;
      vsel_r <= 5'h00;
    end else if (a_wr_r) begin
      if (a_addr_r == `MBSD_OFF_CTRL)
        ctrl_r <= hwdata[3:0];
      if (a_addr_r == `MBSD_OFF_MBINFO)
        mbinfo_r <= hwdata[20:0];
      if (a_addr_r == `MBSD_OFF_PATTERN)
        pattern_r <= hwdata[23:0];
      if (a_addr_r == `MBSD_OFF_VSEL)
        vsel_r <= hwdata[4:0];
    end
  end
  // ------------------------------------------------------------
  // type conversion
  // ------------------------------------------------------------
  wire skip_off = ctrl_r[`MBSD_CTRL_SKIPOFF];
  wire dir_off = ctrl_r[`MBSD_CTRL_DIROFF];
  wire mbaff = ctrl_r[`MBSD_CTRL_MBAFF];
  wire pslice = ctrl_r[`MBSD_CTRL_PSLICE];
  wire hint = mbinfo_r[`MBSD_MB_SKIPHINT];
  wire pb_off = mbinfo_r[`MBSD_MB_PBOFF];
  wire second = mbinfo_r[`MBSD_MB_SECOND];
  wire fld = mbinfo_r[`MBSD_MB_FIELD];
  wire pattern_nz = mbinfo_r[`MBSD_MB_CBPNZ];
  wire [4:0] in_type = mbinfo_r[`MBSD_MB_TYPE_MSB:`MBSD_MB_TYPE_LSB];
  wire [3:0] dpat = pattern_r[`MBSD_PAT_DIR_LSB +: 4];
  wire [7:0] shapes = pattern_r[`MBSD_PAT_SHP_LSB +: 8];
  wire [7:0] preds = pattern_r[`MBSD_PAT_PRD_LSB +: 8];
  reg ref_fld;
  reg permit;
  reg o_skip;
  reg [4:0] o_type;
  reg o_cbpz;
  reg is_direct;
  always @* begin
    // neighbour a first, then b, else compare against zero
    if (mbinfo_r[`MBSD_MB_AVAIL_A])
      ref_fld = mbinfo_r[`MBSD_MB_FIELD_A];
    else if (mbinfo_r[`MBSD_MB_AVAIL_B])
      ref_fld = mbinfo_r[`MBSD_MB_FIELD_B];
    else
      ref_fld = 1'b0;
    if (!mbaff)
      permit = 1'b1; // RULE8
    else if (!second)
      permit = 1'b1; // RULE9
    else
      permit = !((fld != ref_fld) && first_skip_r); // RULE10
    is_direct = in_type == `MBSD_TYPE_P8X8 && dpat == 4'hf;
    o_skip = 1'b0;
    o_type = in_type;
    o_cbpz = !pattern_nz;
    if (hint) begin
      o_cbpz = 1'b1;
      if (permit) begin
        o_skip = 1'b1; // RULE1
        o_type = `MBSD_TYPE_DIRECT;
      end else if (pslice) begin
        o_type = `MBSD_TYPE_L0; // RULE11
      end else begin
        o_type = `MBSD_TYPE_DIRECT; // RULE2
      end
    end else if (is_direct && !pslice) begin
      if (dir_off) begin
        o_type = `MBSD_TYPE_P8X8; // RULE7
      end else if (!pattern_nz && !skip_off && !pb_off && permit) begin
        o_skip = 1'b1; // RULE3
        o_type = `MBSD_TYPE_DIRECT;
      end else begin
        // not permitted, disabled, or nonzero pattern (RULE4 RULE5 RULE6)
        o_type = `MBSD_TYPE_DIRECT; // RULE12
      end
    end
  end
  // ------------------------------------------------------------
  // vector counts
  // ------------------------------------------------------------
  function [3:0] sub_count;
    input d;
    input [1:0] sh;
    input [1:0] pr;
    reg [3:0] base;
    begin
      base = (pr == 2'h2) ? 4'h2 : 4'h1;
      if (d)
        sub_count = 4'h0; // RULE23
      else if (sh == 2'h0)
        sub_count = base;
      else if (sh == 2'h3)
        sub_count = base << 2;
      else
        sub_count = base << 1;
    end
  endfunction
  reg [5:0] cnt_nxt;
  reg big;
  always @* begin
    big = (in_type == `MBSD_TYPE_P8X8) && (shapes != 8'h00);
    if (o_skip)
      cnt_nxt = 6'h00;
    else if (in_type == `MBSD_TYPE_P8X8)
      cnt_nxt = {2'h0, sub_count(dpat[0], shapes[1:0], preds[1:0])}
        + {2'h0, sub_count(dpat[1], shapes[3:2], preds[3:2])}
        + {2'h0, sub_count(dpat[2], shapes[5:4], preds[5:4])}
        + {2'h0, sub_count(dpat[3], shapes[7:6], preds[7:6])}; // RULE22
    else if (in_type <= 5'h02)
      cnt_nxt = 6'h01;
    else if (in_type <= 5'h0b)
      cnt_nxt = 6'h02;
    else if (in_type < 5'h14)
      cnt_nxt = 6'h03;
    else
      cnt_nxt = 6'h04;
  end
  // ------------------------------------------------------------
  // expansion readback
  // ------------------------------------------------------------
  mbsd_mv_slot u_slot (
    .slot(vsel_r),
    .big(big),
    .ptype(in_type),
    .shapes(shapes),
    .src(src)
  );
  // compact inputs already zero absent lists, so copies stay zero (RULE15 RULE21)
  assign vword = (!big && vsel_r[4:3] != 2'h0) ? 32'h00000000 : mv_r[src];
  // read data is fetched in the address phase so it stands through the zero-wait
  // data phase; a read right behind a write to the same register sees the old value
  always @* begin
    case ({haddr[7:2], 2'h0})
      `MBSD_OFF_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
      `MBSD_OFF_MBINFO: rdata_nxt = {11'h000, mbinfo_r};
      `MBSD_OFF_PATTERN: rdata_nxt = {8'h00, pattern_r};
      `MBSD_OFF_RESULT: rdata_nxt = {10'h000, packed_vector_count,
        vector_block_size, 3'h0, partition_type_code, coded_block_pattern_zero,
        skip_hint_flag};
      `MBSD_OFF_STATUS: rdata_nxt = {29'h00000000, first_skip_r, permit,
        result_valid};
      `MBSD_OFF_VSEL: rdata_nxt = {27'h0000000, vsel_r};
      `MBSD_OFF_VDATA: rdata_nxt = vword;
      default: rdata_nxt = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (hready && hsel && htrans[1] && !hwrite)
        hrdata <= rdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // result register
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_hint_flag <= 1'b0;
      partition_type_code <= 5'h00;
      coded_block_pattern_zero <= 1'b0;
      vector_block_size <= 6'h00;
      packed_vector_count <= 6'h00;
      result_valid <= 1'b0;
      first_skip_r <= 1'b0;
    end else begin
      result_valid <= start;
      if (start) begin
        skip_hint_flag <= o_skip;
        partition_type_code <= o_type;
        coded_block_pattern_zero <= o_cbpz;
        vector_block_size <= big ? `MBSD_SIZE_32 : `MBSD_SIZE_8; // RULE14
        packed_vector_count <= cnt_nxt;
        if (!second)
          first_skip_r <= o_skip;
      end
    end
  end
endmodule // mbsd_conv
`default_nettype wire

// file: rtl/mbsd_mv_slot.v
// one unpacked vector slot: picks its source vector for the macroblock shape
// assumes compact input vectors ordered per sub-block as l0,l1 pairs
`timescale 1ns/10ps
`default_nettype none
module mbsd_mv_slot (
  input wire [4:0] slot,
  input wire big,
  input wire [4:0] ptype,
  input wire [7:0] shapes,
  output reg [4:0] src
);
  reg [1:0] q;
  reg [1:0] s;
  reg [1:0] sh;
  reg l1;
  always @* begin
    l1 = slot[0];
    src = 5'h00;
    if (!big) begin
      q = slot[2:1];
      s = 2'h0;
      sh = 2'h0;
      // 16x16 replicates quadrant 0, 16x8 top/bottom, 8x16 left/right
      if (ptype == `MBSD_TYPE_P8X8)
        src = {1'b0, q, 1'b0, l1}; // RULE18
      else if (ptype <= 5'h03)
        src = {4'h0, l1}; // RULE16
      else if (ptype[0] == 1'b0)
        src = {1'b0, q[1], 1'b0, 1'b0, l1}; // RULE17
      else
        src = {1'b0, 1'b0, q[0], 1'b0, l1}; // RULE17
    end else begin
      q = slot[4:3];
      s = slot[2:1];
      sh = shapes[2*q +: 2];
      // 8x8 fills four slots, 8x4 rows, 4x8 columns, 4x4 its own
      case (sh)
        2'h0: src = {q, 2'h0, l1}; // RULE19
        2'h1: src = {q, s[1], 1'b0, l1}; // RULE19
        2'h2: src = {q, 1'b0, s[0], l1}; // RULE19
        default: src = {q, s, l1}; // RULE20
      endcase
    end
  end
endmodule // mbsd_mv_slot
`default_nettype wire

// file: rtl/mbsd_regs.vh
// constants for the b-slice skip/direct converter and vector unpacker
// assumes inclusion by bare name from the design files
`ifndef MBSD_REGS_VH
`define MBSD_REGS_VH
// register byte offsets
`define MBSD_OFF_CTRL 8'h00
`define MBSD_OFF_MBINFO 8'h04
`define MBSD_OFF_PATTERN 8'h08
`define MBSD_OFF_CMD 8'h0c
`define MBSD_OFF_RESULT 8'h10
`define MBSD_OFF_STATUS 8'h14
`define MBSD_OFF_VSEL 8'h18
`define MBSD_OFF_VDATA 8'h1c
`define MBSD_OFF_MVIN 8'h40
// control bits
`define MBSD_CTRL_SKIPOFF 0
`define MBSD_CTRL_DIROFF 1
`define MBSD_CTRL_MBAFF 2
`define MBSD_CTRL_PSLICE 3
// macroblock info bits
`define MBSD_MB_SKIPHINT 0
`define MBSD_MB_PBOFF 1
`define MBSD_MB_SECOND 2
`define MBSD_MB_FIELD 3
`define MBSD_MB_AVAIL_A 4
`define MBSD_MB_AVAIL_B 5
`define MBSD_MB_FIELD_A 6
`define MBSD_MB_FIELD_B 7
`define MBSD_MB_CBPNZ 8
`define MBSD_MB_TYPE_LSB 16
`define MBSD_MB_TYPE_MSB 20
// pattern word: direct pattern 3:0, shapes 15:8, directions 23:16
`define MBSD_PAT_DIR_LSB 0
`define MBSD_PAT_SHP_LSB 8
`define MBSD_PAT_PRD_LSB 16
// partition type codes
`define MBSD_TYPE_DIRECT 5'h00
`define MBSD_TYPE_L0 5'h01
`define MBSD_TYPE_P8X8 5'h16
`define MBSD_TYPE_BIBI8X16 5'h15
// vector counts
`define MBSD_SIZE_8 6'h08
`define MBSD_SIZE_32 6'h20
`define MBSD_MV_WORDS 32
`endif

// file: test/mbsd_coder_model.sv
// syntax coder stand-in: takes one symbol set per result pulse
// assumes result outputs settle with the pulse
`timescale 1ns/10ps
`default_nettype none
module mbsd_coder_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic result_valid,
  output var int n_coded
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_coded <= 0;
    end else if (result_valid) begin
      n_coded <= n_coded + 1;
    end
  end
endmodule // mbsd_coder_model
`default_nettype wire

// file: test/mbsd_conv_properties.sv
// port assertions for the skip/direct converter
// assumes binding into mbsd_conv on one clock
`timescale 1ns/10ps
`default_nettype none
module mbsd_conv_properties #(parameter MV_WORDS = 32) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic skip_hint_flag,
  input wire logic [4:0] partition_type_code,
  input wire logic coded_block_pattern_zero,
  input wire logic [5:0] vector_block_size,
  input wire logic [5:0] packed_vector_count,
  input wire logic result_valid
);
  logic cmd_ap_r;
  // command address phase seen, data follows next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ap_r <= 1'b0;
    end else begin
      cmd_ap_r <= hsel && hready && htrans[1] && hwrite && haddr == 8'h0c;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_zero_wait: assert property (hreadyout) else $error("slave inserted a wait");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_cmd_result: assert property (cmd_ap_r && hwdata[0] |=> result_valid)
    else $error("command gave no result");
  a_valid_cause: assert property (result_valid |-> $past(cmd_ap_r))
    else $error("result without command");
  a_hold_result: assert property (!result_valid |-> $stable({skip_hint_flag,
    partition_type_code, coded_block_pattern_zero, packed_vector_count}))
    else $error("result changed between commands");
  a_skip_cbpz: assert property (skip_hint_flag |-> coded_block_pattern_zero
    && partition_type_code == 5'h00) else $error("skip with pattern or type");
  a_skip_count: assert property (skip_hint_flag |-> packed_vector_count == 6'h00)
    else $error("skip carries vectors");
  a_size_legal: assert property (result_valid |-> vector_block_size == 6'h08
    || vector_block_size == 6'h20) else $error("bad block size");
  a_size32_type: assert property (vector_block_size == 6'h20 |->
    (partition_type_code == 5'h16 || partition_type_code == 5'h00))
    else $error("size 32 on large partition");
  c_skip: cover property (result_valid && skip_hint_flag);
  c_size32: cover property (result_valid && vector_block_size == 6'h20);
  c_p8x8: cover property (result_valid && partition_type_code == 5'h16);
endmodule // mbsd_conv_properties
bind mbsd_conv mbsd_conv_properties #(.MV_WORDS(MV_WORDS)) u_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .skip_hint_flag(skip_hint_flag), .partition_type_code(partition_type_code),
  .coded_block_pattern_zero(coded_block_pattern_zero), .vector_block_size(vector_block_size),
  .packed_vector_count(packed_vector_count), .result_valid(result_valid));
`default_nettype wire

// file: test/mbsd_conv_test.sv
// self-checking bench for the skip/direct converter
// assumes the coder model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module mbsd_conv_test;
  logic hclk, hresetn, hwrite, hreadyout, hresp, skip, cbpz, valid;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0] ptype;
  logic [5:0] vsize, vcnt;
  int error_cnt, n_checks, n_cmd, n_coded;
  mbsd_conv dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .skip_hint_flag(skip),
    .partition_type_code(ptype), .coded_block_pattern_zero(cbpz), .vector_block_size(vsize),
    .packed_vector_count(vcnt), .result_valid(valid));
  mbsd_coder_model coder (.hclk(hclk), .hresetn(hresetn), .result_valid(valid),
    .n_coded(n_coded));
  // --------------------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic mb(input logic [3:0] c, input logic [31:0] i, p, input logic s,
      input logic [4:0] t, input logic z);
    int k;
    bus(1'b1, 8'h00, {28'h0, c});
    bus(1'b1, 8'h04, i);
    bus(1'b1, 8'h08, p);
    bus(1'b1, 8'h0c, 32'h1);
    n_cmd++;
    for (k = 0; k < 8 && valid !== 1'b1; k++) @(negedge hclk);
    chk(valid === 1'b1 && skip === s && ptype === t && cbpz === z, "coded macroblock");
    @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd[6:0] === {t, z, s}, "result word");
  endtask
  task automatic vs(input logic [4:0] s, input logic [31:0] e);
    bus(1'b1, 8'h18, {27'h0, s});
    bus(1'b0, 8'h1c, 32'h0);
    chk(rd === e, "expanded vector");
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_conv;
    mb(4'h1, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h0, 32'h0016_0000, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h1, 32'h0016_0000, 32'hf, 1'b0, 5'h00, 1'b1);
    mb(4'h0, 32'h0016_0100, 32'hf, 1'b0, 5'h00, 1'b0);
    mb(4'h2, 32'h0016_0000, 32'hf, 1'b0, 5'h16, 1'b1);
    mb(4'h0, 32'h0016_0002, 32'hf, 1'b0, 5'h00, 1'b1);
  endtask
  task automatic t_pair;
    mb(4'h4, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_001d, 32'hf, 1'b0, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_005d, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_000d, 32'hf, 1'b0, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_00ad, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_001c, 32'hf, 1'b0, 5'h00, 1'b1);
    mb(4'h4, 32'h0016_0100, 32'hf, 1'b0, 5'h00, 1'b0);
    mb(4'h4, 32'h0016_001d, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h0, 32'h0016_0001, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'h0, 32'h0016_001d, 32'hf, 1'b1, 5'h00, 1'b1);
    mb(4'hc, 32'h0001_0001, 32'h0, 1'b1, 5'h00, 1'b1);
    mb(4'hc, 32'h0001_001d, 32'h0, 1'b0, 5'h01, 1'b1);
  endtask
  task automatic t_count;
    mb(4'h0, 32'h0016_0000, 32'h00aa_0000, 1'b0, 5'h16, 1'b1);
    chk(vcnt === 6'h08 && vsize === 6'h08, "bi 8x8 count");
    mb(4'h0, 32'h0016_0000, 32'h00a8_0100, 1'b0, 5'h16, 1'b1);
    chk(vcnt === 6'h08 && vsize === 6'h20, "8x4 count");
    mb(4'h0, 32'h0016_0000, 32'h0000_ff00, 1'b0, 5'h16, 1'b1);
    chk(vcnt === 6'h10 && vsize === 6'h20, "4x4 count");
    mb(4'h0, 32'h0016_0000, 32'h0002_0200, 1'b0, 5'h16, 1'b1);
    chk(vcnt === 6'h07 && vsize === 6'h20, "4x8 count");
    mb(4'h0, 32'h0016_0000, 32'h00aa_0001, 1'b0, 5'h16, 1'b1);
    chk(vcnt === 6'h06 && vsize === 6'h08, "direct sub count");
  endtask
  task automatic t_vec;
    bus(1'b1, 8'h40, 32'hfffd_0007);
    bus(1'b1, 8'h44, 32'h0);
    bus(1'b1, 8'h50, 32'h0004_fff9);
    bus(1'b1, 8'h54, 32'h0);
    mb(4'h0, 32'h0005_0000, 32'h0, 1'b0, 5'h05, 1'b1);
    chk(vsize === 6'h08 && vcnt === 6'h02, "8x16 size");
    vs(5'h04, 32'hfffd_0007);
    vs(5'h02, 32'h0004_fff9);
    vs(5'h03, 32'h0);
    vs(5'h06, 32'h0004_fff9);
    vs(5'h09, 32'h0);
    mb(4'h0, 32'h0016_0000, 32'h0000_0100, 1'b0, 5'h16, 1'b1);
    chk(vsize === 6'h20 && vcnt === 6'h05, "8x4 split count");
    vs(5'h02, 32'hfffd_0007);
    vs(5'h06, 32'h0004_fff9);
    bus(1'b0, 8'h30, 32'h0);
    chk(rd === 32'h0, "unmapped read");
  endtask
  task automatic results;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_conv;
    t_pair;
    t_count;
    t_vec;
    chk(n_coded === n_cmd, "coder count");
    results;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    results;
  end
endmodule // mbsd_conv_test
`default_nettype wire
